// [logic/mcu_opcode_decode_timing.sv]
// Functional notes
// - Every instruction is one to three bytes and finishes in 2 to 32 cycles.
// - Plain add: 28-2F register, 25 direct, 24 immediate, two cycles.
// - Plain add from indirect memory: 26-27, one byte, two cycles.
// - Add with carry: 38-3F, 35, 34, 36-37, two cycles, accumulator result.
// - Subtract with borrow: 98-9F, 95, 94, 96-97, two cycles.
// - AND into accumulator: 58-5F, 56-57, 55, 54, two cycles.
// - AND into direct byte: 52 two bytes two cycles, 53 three bytes four cycles.
// - OR into direct byte: 42 two cycles, 43 three bytes four cycles.
// - XOR into accumulator: 68-6F, 65, 64, 66-67, two cycles.
// - XOR into direct byte: 62 two cycles, 63 three bytes four cycles.
// - Rotates 33, 13, 23, 03: one byte, two cycles each.
// - Code memory reads 93 and 83 take eight cycles.
// - External reads E0 and E2-E3 take eight cycles.
// - External writes F0 and F2-F3: one byte, eight cycles.
// - Direct to direct copy 85: three bytes, four cycles.
// - Load data pointer immediate 90: three bytes, four cycles.
// - Push C0 and pop D0: two bytes, four cycles.
// - Exchange with register C8-CF, direct C5, indirect C6-C7, two cycles.
// - Nibble exchange D6-D7: one byte, two cycles.
// - AND bit into carry 82, inverse B0: two bytes, four cycles.
// - OR bit into carry 72, inverse A0: four cycles.
// - Bit to carry A2 two cycles; carry to bit 92 four cycles.
// - Eight-code ranges pick the working register from opcode bits 2:0.
// - Wide option clear: 8x8 multiply, 8/8 divide; set: 16-bit operands.
// - With wide option set, long divide select picks 32/16 over 16/16.
`timescale 1ns/10ps
`default_nettype none
module mcu_opcode_decode_timing (
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire opdec_pkg::fetch_t instr_in,
  input  wire logic              wide_arith_enable,
  input  wire logic              long_divide_select,
  output var  logic              ready_r,
  output var  logic              busy_r,
  output var  logic              done_r,
  output var  opdec_pkg::dec_t   dec_r
);
  import opdec_pkg::*;

  typedef enum logic {seq_idle, seq_exec} seq_t;

  logic       rst_meta_r;
  logic       rst_sync_r;
  seq_t       state_r;
  seq_t       state_nxt;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic       ready_nxt;
  logic       busy_nxt;
  logic       done_nxt;
  dec_t       dec_nxt;

  function automatic dec_t decode_op(input logic [7:0] opc, input logic wide, input logic long_div);
    dec_t       d;
    logic       col;
    opnd_t      m;
    logic [1:0] ml;
    d = DEC_RST;
    d.supported = 1'b1;
    d.working_register = opc[2:0];
    d.indirect_pointer_register = opc[0];
    col = opc[3] || (opc[3:2] == 2'b01 && opc[1:0] != 2'b00);
    m = opnd_working;
    ml = LEN_1;
    if (!opc[3]) begin
      unique case (opc[1:0])
        2'b00: begin
          m = opnd_immediate;
          ml = LEN_2;
        end
        2'b01: begin
          m = opnd_direct;
          ml = LEN_2;
        end
        default: m = opnd_indirect;
      endcase
    end
    if (opc[3:0] == 4'h4) begin
      col = 1'b1;
    end
    d.src = m;
    d.length = ml;
    d.dst = opnd_acc;
    casez (opc)
      8'h00: d.op = op_nop;
      8'h03, 8'h13, 8'h23, 8'h33: begin
        d.op = opc[5] ? (opc[4] ? rotate_left_via_carry : op_rotate_left)
                      : (opc[4] ? rotate_right_via_carry : op_rotate_right);
        d.src = opnd_acc;
        d.length = LEN_1;
      end
      8'h42, 8'h52, 8'h62, 8'h43, 8'h53, 8'h63: begin
        d.op = (opc[5:4] == 2'b00) ? bitwise_or_op : (opc[4] ? bitwise_and_op : bitwise_xor_op);
        d.src = opc[0] ? opnd_immediate : opnd_acc;
        d.dst = opnd_direct;
        d.length = opc[0] ? LEN_3 : LEN_2;
        d.cycles = opc[0] ? CYC_4 : CYC_2;
      end
      8'h04, 8'h14: begin
        d.op = opc[4] ? op_decrement : op_increment;
        d.src = opnd_acc;
        d.length = LEN_1;
      end
      8'h0?, 8'h1?: begin
        d.op = opc[4] ? op_decrement : op_increment;
        d.dst = m;
        d.supported = col;
      end
      8'h2?: begin
        d.op = op_add;
        d.supported = col;
      end
      8'h3?: begin
        d.op = add_with_carry;
        d.supported = col;
      end
      8'h4?: begin
        d.op = bitwise_or_op;
        d.supported = col;
      end
      8'h5?: begin
        d.op = bitwise_and_op;
        d.supported = col;
      end
      8'h6?: begin
        d.op = bitwise_xor_op;
        d.supported = col;
      end
      8'h9?: begin
        d.op = subtract_with_borrow;
        d.supported = col && opc != 8'h90 && opc != 8'h92 && opc != 8'h93;
      end
      default: d.supported = 1'b0;
    endcase
    case (opc)
      8'h90: begin
        d.op = op_load_pointer;
        d.src = opnd_immediate;
        d.dst = opnd_pointer;
        d.length = LEN_3;
        d.cycles = CYC_4;
        d.supported = 1'b1;
      end
      8'h93, 8'h83: begin
        d.op = code_memory_read;
        d.src = opnd_code;
        d.length = LEN_1;
        d.cycles = CYC_8;
        d.supported = 1'b1;
      end
      8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
        d.op = external_data_move;
        d.src = opc[4] ? opnd_acc : opnd_external;
        d.dst = opc[4] ? opnd_external : opnd_acc;
        d.length = LEN_1;
        d.cycles = CYC_8;
        d.supported = 1'b1;
      end
      8'ha3: begin
        d.op = op_increment_pointer;
        d.src = opnd_pointer;
        d.dst = opnd_pointer;
        d.cycles = CYC_4;
        d.supported = 1'b1;
      end
      8'ha4: begin
        d.op = multiply_op;
        d.src = opnd_acc;
        d.length = LEN_1;
        d.cycles = wide ? CYC_16 : CYC_8;
        d.supported = 1'b1;
      end
      8'h84: begin
        d.op = op_divide;
        d.src = opnd_acc;
        d.length = LEN_1;
        d.cycles = !wide ? CYC_8 : (long_div ? CYC_32 : CYC_16);
        d.supported = 1'b1;
      end
      8'hd4, 8'he4, 8'hf4, 8'hc4: begin
        d.op = (opc == 8'hd4) ? op_decimal_adjust : (opc == 8'he4) ? op_clear
             : (opc == 8'hf4) ? complement_op : op_nibble_swap;
        d.src = opnd_acc;
        d.length = LEN_1;
        d.supported = 1'b1;
      end
      8'h85, 8'h75: begin
        d.op = op_move;
        d.src = opc[7] ? opnd_direct : opnd_immediate;
        d.dst = opnd_direct;
        d.length = LEN_3;
        d.cycles = CYC_4;
        d.supported = 1'b1;
      end
      8'h74: begin
        d.op = op_move;
        d.src = opnd_immediate;
        d.length = LEN_2;
        d.supported = 1'b1;
      end
      8'hc0, 8'hd0: begin
        d.op = opc[4] ? op_pop : op_push;
        d.src = opc[4] ? opnd_none : opnd_direct;
        d.dst = opc[4] ? opnd_direct : opnd_none;
        d.length = LEN_2;
        d.cycles = CYC_4;
        d.supported = 1'b1;
      end
      8'hd6, 8'hd7: begin
        d.op = nibble_exchange;
        d.supported = 1'b1;
      end
      8'hc3, 8'hd3, 8'hb3, 8'hc2, 8'hd2, 8'hb2: begin
        d.op = (opc[7:4] == 4'hc) ? op_clear : (opc[7:4] == 4'hd) ? set_bit_op : complement_op;
        d.src = opc[0] ? opnd_carry : opnd_bit;
        d.dst = d.src;
        d.length = opc[0] ? LEN_1 : LEN_2;
        d.supported = 1'b1;
      end
      8'h82, 8'hb0, 8'h72, 8'ha0: begin
        d.op = (opc == 8'h82) ? bitwise_and_op : (opc == 8'hb0) ? op_and_inverse_bit
             : (opc == 8'h72) ? bitwise_or_op : op_or_inverse_bit;
        d.src = opnd_bit;
        d.dst = opnd_carry;
        d.length = LEN_2;
        d.cycles = CYC_4;
        d.supported = 1'b1;
      end
      8'ha2, 8'h92: begin
        d.op = op_move;
        d.src = opc[4] ? opnd_carry : opnd_bit;
        d.dst = opc[4] ? opnd_bit : opnd_carry;
        d.length = LEN_2;
        d.cycles = opc[4] ? CYC_4 : CYC_2;
        d.supported = 1'b1;
      end
      default: begin
        if (opc[7:4] == 4'hc && col && opc[3:0] != 4'h4) begin
          d.op = accumulator_exchange;
          d.supported = 1'b1;
        end else if (opc[7:4] == 4'he && col && opc[3:0] != 4'h4) begin
          d.op = op_move;
          d.supported = 1'b1;
        end else if (opc[7:4] == 4'hf && col && opc[3:0] != 4'h4) begin
          d.op = op_move;
          d.dst = m;
          d.src = opnd_acc;
          d.supported = 1'b1;
        end else if (opc[7:4] == 4'h7 && opc[3:1] != 3'h2 && col) begin
          d.op = op_move;
          d.dst = m;
          d.src = opnd_immediate;
          d.length = LEN_2;
          d.supported = 1'b1;
        end else if ((opc[7:4] == 4'ha || opc[7:4] == 4'h8) && opc[3:1] != 3'h2 && col) begin
          d.op = op_move;
          d.src = opc[5] ? opnd_direct : m;
          d.dst = opc[5] ? m : opnd_direct;
          d.length = LEN_2;
          d.cycles = CYC_4;
          d.supported = 1'b1;
        end
      end
    endcase
    // Refused codes report one byte so a fetcher never skips operands
    if (!d.supported) begin
      d.op = op_unsupported;
      d.length = LEN_1;
    end
    return d;
  endfunction

  // Reset released through two stages; asserted at once
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Execution timer: busy for exactly the decoded cycle count
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dec_nxt = dec_r;
    done_nxt = 1'b0;
    busy_nxt = busy_r;
    unique case (state_r)
      seq_idle: begin
        if (instr_in.valid) begin
          dec_nxt = decode_op(instr_in.opcode, wide_arith_enable, long_divide_select);
          cnt_nxt = dec_nxt.cycles;
          state_nxt = seq_exec;
          busy_nxt = 1'b1;
        end
      end
      seq_exec: begin
        cnt_nxt = cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          state_nxt = seq_idle;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
    endcase
    ready_nxt = (state_nxt == seq_idle);
  end

  // Options are sampled only at acceptance, so changes mid-instruction are safe
  always_ff @(posedge mclk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= seq_idle;
      cnt_r <= CNT_RST;
      dec_r <= DEC_RST;
      ready_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dec_r <= dec_nxt;
      ready_r <= ready_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

endmodule // mcu_opcode_decode_timing
`default_nettype wire

// [logic/opdec_pkg.sv]
`default_nettype none
package opdec_pkg;

  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  localparam logic [5:0] CYC_2  = 6'h02;
  localparam logic [5:0] CYC_4  = 6'h04;
  localparam logic [5:0] CYC_8  = 6'h08;
  localparam logic [5:0] CYC_16 = 6'h10;
  localparam logic [5:0] CYC_32 = 6'h20;

  localparam logic [5:0] CNT_RST = 6'h00;

  typedef enum logic [5:0] {
    op_unsupported, op_nop, op_add, add_with_carry, subtract_with_borrow,
    op_increment, op_decrement, op_increment_pointer, multiply_op, op_divide,
    op_decimal_adjust, bitwise_and_op, bitwise_or_op, bitwise_xor_op,
    op_clear, complement_op, op_nibble_swap, op_rotate_left, rotate_left_via_carry,
    op_rotate_right, rotate_right_via_carry, op_move, op_load_pointer,
    code_memory_read, external_data_move, op_push, op_pop,
    accumulator_exchange, nibble_exchange, set_bit_op, op_and_inverse_bit,
    op_or_inverse_bit
  } op_t;

  typedef enum logic [3:0] {
    opnd_none, opnd_acc, opnd_working, opnd_direct, opnd_indirect,
    opnd_immediate, opnd_carry, opnd_bit, opnd_pointer, opnd_code,
    opnd_external
  } opnd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
  } fetch_t;

  typedef struct packed {
    op_t        op;
    logic [1:0] length;
    logic [5:0] cycles;
    opnd_t      src;
    opnd_t      dst;
    logic [2:0] working_register;
    logic       indirect_pointer_register;
    logic       supported;
  } dec_t;

  localparam dec_t DEC_RST = '{op_nop, LEN_1, CYC_2, opnd_none, opnd_none, 3'h0, 1'b0, 1'b0};

endpackage
`default_nettype wire

// [verification/opdec_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module opdec_chk (
  input wire logic              mclk,
  input wire logic              nrst,
  input wire opdec_pkg::fetch_t instr_in,
  input wire logic              wide_arith_enable,
  input wire logic              long_divide_select,
  input wire logic              ready_r,
  input wire logic              busy_r,
  input wire logic              done_r,
  input wire opdec_pkg::dec_t   dec_r
);
  import opdec_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  // Clears when idle so a refused offer cannot stretch it
  always_comb cnt_nxt = busy_r ? cnt_r + 6'h01 : 6'h00;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) cnt_r <= 6'h00;
    else cnt_r <= cnt_nxt;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_take_busy: assert property (ready_r && instr_in.valid |=> busy_r && !ready_r)
    else $error("accepted opcode did not start busy");
  a_busy_length: assert property ($fell(busy_r) |-> cnt_r == dec_r.cycles)
    else $error("busy length differs from decoded cycles");
  a_done_pulse: assert property ($fell(busy_r) |-> done_r ##1 !done_r)
    else $error("done not a single pulse after busy");
  a_done_cause: assert property (done_r |-> $past(busy_r) && !busy_r)
    else $error("done without preceding busy");
  a_cycle_range: assert property (
    busy_r |-> dec_r.cycles inside {[CYC_2:CYC_32]} && dec_r.length inside {[LEN_1:LEN_3]})
    else $error("length or cycles out of range");
  a_reg_select: assert property ($rose(busy_r) |->
    dec_r.working_register == $past(instr_in.opcode[2:0]) &&
    dec_r.indirect_pointer_register == $past(instr_in.opcode[0]))
    else $error("register select not from opcode bits");
  a_hold_decode: assert property (!ready_r |=> $stable(dec_r))
    else $error("decode changed while not ready");
  a_mul_width: assert property ($rose(busy_r) && dec_r.op == multiply_op |->
    dec_r.cycles == ($past(wide_arith_enable) ? CYC_16 : CYC_8))
    else $error("multiply cycles wrong for width");
  a_div_width: assert property ($rose(busy_r) && dec_r.op == op_divide |->
    dec_r.cycles == (!$past(wide_arith_enable) ? CYC_8 : $past(long_divide_select) ? CYC_32 : CYC_16))
    else $error("divide cycles wrong for width");
  a_ready_idle: assert property (ready_r |-> !busy_r)
    else $error("ready while busy");
  c_mul: cover property ($fell(busy_r) && dec_r.op == multiply_op);
  c_b2b: cover property (done_r && instr_in.valid);
  c_refuse: cover property (busy_r && instr_in.valid);
endmodule // opdec_chk
`default_nettype wire

// [verification/prog_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
  input  wire logic              mclk,
  input  wire logic              req,
  input  wire logic [7:0]        code,
  output var  opdec_pkg::fetch_t fetch
);
  import opdec_pkg::*;
  logic [7:0] last_r = 8'h00;
  // Idle bus toggles so a stale opcode never looks valid
  always @(posedge mclk) last_r <= fetch.opcode;
  always_comb begin
    fetch.valid = req;
    fetch.opcode = req ? code : ~last_r;
  end
endmodule // prog_mem
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import opdec_pkg::*;
  logic       mclk;
  logic       nrst;
  logic       req;
  logic       wide;
  logic       lng;
  logic       ready_r;
  logic       busy_r;
  logic       done_r;
  logic [7:0] code;
  fetch_t     fetch;
  dec_t       dec_r;
  int         n_errors = 0;
  int         checked = 0;
  prog_mem u_prog_mem (.mclk(mclk), .req(req), .code(code), .fetch(fetch));
  mcu_opcode_decode_timing u_mcu_opcode_decode_timing (.mclk(mclk), .nrst(nrst), .instr_in(fetch),
    .wide_arith_enable(wide), .long_divide_select(lng), .ready_r(ready_r), .busy_r(busy_r),
    .done_r(done_r), .dec_r(dec_r));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Entry: opcode, op code (ff skips, 00 unsupported), length, cycles
  task automatic run(input logic [27:0] e, input logic w, input logic l);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ready_r !== 1'b1 && n < 100);
    chk(32'(ready_r), 32'h1);
    wide = w;
    lng = l;
    code = e[27:20];
    req = 1'b1;
    @(negedge mclk);
    req = 1'b0;
    n = 0;
    while (busy_r === 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(32'(n), 32'(e[7:0]));
    chk(32'(done_r), 32'h1);
    chk(32'(dec_r.length), 32'(e[11:8]));
    chk(32'(dec_r.supported), 32'(e[19:12] != 8'h00));
    chk(32'(dec_r.working_register), 32'(e[22:20]));
    chk(32'(dec_r.indirect_pointer_register), 32'(e[20]));
    if (e[19:12] != 8'hff) chk(32'(dec_r.op), 32'(e[19:12]));
  endtask
  task automatic t_table;
    logic [27:0] tbl[$];
    tbl = {28'h28_02_1_02, 28'h2f_02_1_02, 28'h25_02_2_02, 28'h24_02_2_02,
      28'h26_02_1_02, 28'h27_02_1_02,
      28'h38_03_1_02, 28'h3f_03_1_02, 28'h35_03_2_02, 28'h34_03_2_02, 28'h36_03_1_02,
      28'h98_04_1_02, 28'h9f_04_1_02, 28'h95_04_2_02, 28'h94_04_2_02, 28'h97_04_1_02,
      28'h58_0b_1_02, 28'h56_0b_1_02, 28'h57_0b_1_02, 28'h55_0b_2_02, 28'h54_0b_2_02,
      28'h52_0b_2_02, 28'h53_0b_3_04, 28'h42_0c_2_02, 28'h43_0c_3_04,
      28'h6f_0d_1_02, 28'h65_0d_2_02, 28'h64_0d_2_02, 28'h66_0d_1_02,
      28'h62_0d_2_02, 28'h63_0d_3_04,
      28'h33_12_1_02, 28'h13_14_1_02, 28'h23_11_1_02, 28'h03_13_1_02,
      28'h93_17_1_08, 28'h83_17_1_08, 28'he0_18_1_08, 28'he2_18_1_08, 28'he3_18_1_08,
      28'hf0_18_1_08, 28'hf2_18_1_08, 28'hf3_18_1_08,
      28'h85_15_3_04, 28'h90_16_3_04, 28'hc0_19_2_04, 28'hd0_1a_2_04,
      28'hc8_1b_1_02, 28'hcf_1b_1_02, 28'hc5_1b_2_02, 28'hc6_1b_1_02, 28'hd7_1c_1_02,
      28'h82_ff_2_04, 28'hb0_1e_2_04, 28'h72_ff_2_04, 28'ha0_1f_2_04,
      28'ha2_ff_2_02, 28'h92_ff_2_04, 28'ha5_00_1_02};
    foreach (tbl[i]) run(tbl[i], 1'b0, 1'b0);
  endtask
  task automatic t_muldiv;
    run(28'ha4_08_1_08, 1'b0, 1'b1);
    run(28'ha4_08_1_10, 1'b1, 1'b0);
    run(28'h84_09_1_08, 1'b0, 1'b1);
    run(28'h84_09_1_10, 1'b1, 1'b0);
    run(28'h84_09_1_20, 1'b1, 1'b1);
  endtask
  task automatic t_refuse;
    @(negedge mclk);
    code = 8'h85;
    req = 1'b1;
    @(negedge mclk);
    code = 8'ha4;
    repeat (2) @(negedge mclk);
    req = 1'b0;
    repeat (2) @(negedge mclk);
    chk(32'(done_r), 32'h1);
    chk(32'(dec_r.op), 32'(op_move));
    chk(32'(dec_r.src), 32'(opnd_direct));
    code = 8'he4;
    req = 1'b1;
    @(negedge mclk);
    code = 8'hf4;
    repeat (2) @(negedge mclk);
    chk(32'(done_r), 32'h1);
    @(negedge mclk);
    chk(32'(busy_r), 32'h1);
    chk(32'(dec_r.op), 32'(complement_op));
    req = 1'b0;
  endtask
  task automatic t_reset;
    run(28'h24_02_2_02, 1'b0, 1'b0);
    code = 8'h93;
    req = 1'b1;
    @(negedge mclk);
    req = 1'b0;
    @(negedge mclk);
    nrst = 1'b0;
    #1;
    chk(32'(busy_r), 32'h0);
    chk(32'(dec_r), 32'(DEC_RST));
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    repeat (2) @(negedge mclk);
    chk(32'(ready_r), 32'h0);
    @(negedge mclk);
    chk(32'(ready_r), 32'h1);
  endtask
  initial begin
    nrst = 1'b0;
    req = 1'b0;
    code = 8'h00;
    wide = 1'b0;
    lng = 1'b0;
    repeat (8) @(negedge mclk);
    chk(32'(ready_r), 32'h0);
    nrst = 1'b1;
    t_table;
    t_muldiv;
    t_refuse;
    t_reset;
    run(28'h53_0b_3_04, 1'b0, 1'b0);
    summarize;
  end
  initial begin
    #100000;
    n_errors++;
    summarize;
  end
endmodule // tb
bind mcu_opcode_decode_timing opdec_chk u_opdec_chk (.mclk(mclk), .nrst(nrst), .instr_in(instr_in),
  .wide_arith_enable(wide_arith_enable), .long_divide_select(long_divide_select), .ready_r(ready_r),
  .busy_r(busy_r), .done_r(done_r), .dec_r(dec_r));
`default_nettype wire
